/* File: src/pmcc_map.vh */
// Purpose: constants for the power mode and clock control block
// Assumes: processor clock 20 MHz
// Notes: included by bare name
`ifndef PMCC_MAP_VH
`define PMCC_MAP_VH
// peripheral divider ratio codes
`define DIV_FULL 2'h0
`define DIV_HALF 2'h2
`define DIV_QUARTER 2'h1
`define DIV_RESET 2'h1
// mode states
`define ST_RUN 2'h0
`define ST_IDLE 2'h1
`define ST_PD 2'h2
`define ST_WAKE 2'h3
// external interrupt pins and lines
`define EXT_PINS 9
`define EXT_LINES 4
// wake-up timer
`define WAKE_NS 51200
`define CLK_NS 50
`define WAKE_CYCLES ((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 12
`endif

/* File: src/periph_clk_div.v */
// Purpose: peripheral clock enable divider, full, half or quarter rate
// Assumes: ratio input from same clock domain
// Notes: new ratio loads only at the end of a period
`include "pmcc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module periph_clk_div (
	// clock and reset
	input wire i_core_clk,
	input wire i_nrst,
	// control
	input wire i_run,
	input wire [1:0] i_ratio,
	// divided clock strobe
	output reg o_pclk_en
);
reg [1:0] ratio;
reg [1:0] cnt;
wire [1:0] last = (ratio == `DIV_FULL) ? 2'h0 : (ratio == `DIV_HALF) ? 2'h1 : 2'h3;
// ratio changes only when a whole period ends, avoiding short pulses
always @(posedge i_core_clk) begin
	if (!i_nrst) begin
		ratio <= `DIV_RESET;
		cnt <= 2'h0;
		o_pclk_en <= 1'b0;
	end else if (!i_run) begin
		o_pclk_en <= 1'b0;
	end else if (cnt >= last) begin
		cnt <= 2'h0;
		ratio <= i_ratio;
		o_pclk_en <= 1'b1;
	end else begin
		cnt <= cnt + 2'h1;
		o_pclk_en <= 1'b0;
	end
end
endmodule
`default_nettype wire

/* File: src/ext_irq_combine.v */
// Purpose: nine external interrupt pins into four request lines
// Assumes: pins already synchronised
// Notes: edge flags cleared per pin by software
`include "pmcc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module ext_irq_combine #(
	parameter PINS = `EXT_PINS
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_nrst,
	// pins and configuration
	input wire [PINS-1:0] i_pin,
	input wire [PINS-1:0] i_edge_mode,
	input wire [PINS-1:0] i_pin_en,
	input wire [PINS-1:0] i_clear,
	// requests
	output reg [`EXT_LINES-1:0] o_irq,
	output wire [PINS-1:0] o_active
);
reg [PINS-1:0] prev;
reg [PINS-1:0] flag;
wire [PINS-1:0] rise = i_pin & ~prev;
// pins that share request line 'line': every fourth pin, counted from the line number
function [PINS-1:0] line_mask;
	input integer line;
	integer j;
	begin
		for (j = 0; j < PINS; j = j + 1)
			line_mask[j] = ((j % `EXT_LINES) == line);
	end
endfunction
// level pins pass through, edge pins latch; set beats clear
assign o_active = i_pin_en & ((~i_edge_mode & i_pin) | (i_edge_mode & flag));
integer k;
always @(posedge i_core_clk) begin
	if (!i_nrst) begin
		prev <= {PINS{1'b0}};
		flag <= {PINS{1'b0}};
		o_irq <= {`EXT_LINES{1'b0}};
	end else begin
		prev <= i_pin;
		flag <= (flag & ~i_clear) | rise;
		for (k = 0; k < `EXT_LINES; k = k + 1)
			o_irq[k] <= |(o_active & line_mask(k));
	end
end
endmodule
`default_nettype wire

/* File: src/power_mode_clock_control.v */
// Purpose: idle/power-down control, peripheral gating, divider, remap, wake
// Assumes: oscillator status comes from an analog pin, one core clock
// Notes: clock stop outputs drive external gating cells
// Function
// - idle stops instruction execution until reset or interrupt, then resumes
// - peripherals keep clocking in idle; peripheral interrupt ends idle
// - idle gates processor, memory and bus clocks, not peripherals
// - power-down stops the oscillator, no internal clocks
// - power-down keeps state and holds output pins at last level
// - power-down ends on reset or clockless interrupt
// - each peripheral has its own power-off control
// - peripheral clock at full, half or quarter processor rate
// - divider resets to quarter rate
// - synthesizer keeps running in idle, stops only in power-down
// - remap selects flash or static RAM for vectors at address zero
// - nine external pins, edge or level, combine into four requests
// - each external input optionally wakes from power-down without clock
// - power-down wake waits for oscillator confirmation, then runs the wake-up timer
`include "pmcc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module power_mode_clock_control #(
	parameter NPERIPH = 8,
	parameter WAKE_CYCLES = `WAKE_CYCLES
) (
	// clock and reset
	input wire i_core_clk,
	input wire i_nrst,
	// software control
	input wire i_idle_req,
	input wire i_pd_req,
	input wire [1:0] i_div_ratio,
	input wire i_remap_ram,
	input wire [NPERIPH-1:0] i_periph_off,
	input wire [`EXT_PINS-1:0] i_ext_edge,
	input wire [`EXT_PINS-1:0] i_ext_en,
	input wire [`EXT_PINS-1:0] i_ext_wake_en,
	input wire [`EXT_PINS-1:0] i_ext_clear,
	// events
	input wire i_periph_irq,
	input wire i_osc_ok,
	input wire [`EXT_PINS-1:0] i_ext_pin,
	// clock and mode outputs
	output reg o_cpu_run,
	output reg o_core_clk_en,
	output reg o_periph_clk_en,
	output reg o_osc_on,
	output reg o_pll_keep,
	output reg o_pin_hold,
	output reg o_remap_ram,
	output reg [NPERIPH-1:0] o_periph_clk_on,
	output reg [`EXT_LINES-1:0] o_ext_irq,
	output reg [1:0] o_mode
);
reg [`EXT_PINS-1:0] s1, s2, s3;
reg [1:0] state;
reg [1:0] next_state;
reg [`CNT_W-1:0] wcnt;
reg osc2, osc3;
reg osc1;
wire pclk_en;
wire [`EXT_LINES-1:0] irq;
wire [`EXT_PINS-1:0] wake_raw = i_ext_pin & i_ext_en & i_ext_wake_en;
wire osc_good = osc2 & osc3;
// three-stage sync; a change counts once stages two and three agree
reg [`EXT_PINS-1:0] pin_f;
always @(posedge i_core_clk) begin
	if (!i_nrst) begin
		s1 <= 9'h000;
		s2 <= 9'h000;
		s3 <= 9'h000;
		pin_f <= 9'h000;
		osc1 <= 1'b0;
		osc2 <= 1'b0;
		osc3 <= 1'b0;
	end else begin
		s1 <= i_ext_pin;
		s2 <= s1;
		s3 <= s2;
		pin_f <= (s2 == s3) ? s2 : pin_f;
		osc1 <= i_osc_ok;
		osc2 <= osc1;
		osc3 <= osc2;
	end
end
periph_clk_div u_div (
	.i_core_clk(i_core_clk),
	.i_nrst(i_nrst),
	.i_run(state != `ST_PD),
	.i_ratio(i_div_ratio),
	.o_pclk_en(pclk_en)
);
ext_irq_combine #(.PINS(`EXT_PINS)) u_ext (
	.i_core_clk(i_core_clk),
	.i_nrst(i_nrst),
	.i_pin(pin_f),
	.i_edge_mode(i_ext_edge),
	.i_pin_en(i_ext_en),
	.i_clear(i_ext_clear),
	.o_irq(irq),
	.o_active()
);
// mode sequencing; power-down wake uses raw pin level since no clock runs
always @* begin
	next_state = state;
	case (state)
	`ST_RUN: begin
		if (i_pd_req)
			next_state = `ST_PD;
		else if (i_idle_req)
			next_state = `ST_IDLE;
	end
	`ST_IDLE: begin
		if (i_periph_irq || (|irq))
			next_state = `ST_RUN;
	end
	`ST_PD: begin
		if (|wake_raw)
			next_state = `ST_WAKE;
	end
	`ST_WAKE: begin
		if (osc_good && wcnt >= WAKE_CYCLES[`CNT_W-1:0] - 1'b1)
			next_state = `ST_RUN;
	end
	default: next_state = `ST_RUN;
	endcase
end
// state, wake timer, and registered outputs
always @(posedge i_core_clk) begin
	if (!i_nrst) begin
		state <= `ST_RUN;
		wcnt <= {`CNT_W{1'b0}};
		o_cpu_run <= 1'b1;
		o_core_clk_en <= 1'b1;
		o_periph_clk_en <= 1'b0;
		o_osc_on <= 1'b1;
		o_pll_keep <= 1'b1;
		o_pin_hold <= 1'b0;
		o_remap_ram <= 1'b0;
		o_periph_clk_on <= {NPERIPH{1'b1}};
		o_ext_irq <= 4'h0;
		o_mode <= `ST_RUN;
	end else begin
		state <= next_state;
		if (state == `ST_WAKE && osc_good)
			wcnt <= wcnt + 1'b1;
		else
			wcnt <= {`CNT_W{1'b0}};
		o_cpu_run <= (next_state == `ST_RUN);
		o_core_clk_en <= (next_state == `ST_RUN);
		o_periph_clk_en <= pclk_en & (next_state != `ST_PD);
		o_osc_on <= (next_state != `ST_PD);
		o_pll_keep <= (next_state != `ST_PD);
		o_pin_hold <= (next_state == `ST_PD) || (next_state == `ST_WAKE);
		o_remap_ram <= i_remap_ram;
		o_periph_clk_on <= ~i_periph_off;
		o_ext_irq <= irq;
		o_mode <= next_state;
	end
end
endmodule
`default_nettype wire

/* File: sim/osc_model.sv */
// Purpose: oscillator start-up model
// Assumes: one core clock
// Notes: ok lags enable by five cycles
`timescale 1ns/1ps
`default_nettype none
module osc_model (
	input wire i_core_clk,
	input wire i_osc_on,
	output wire o_osc_ok
);
	reg [2:0] cnt = 3'h0;
	// start-up delay, so the wake timer really has to wait
	always @(posedge i_core_clk) cnt <= !i_osc_on ? 3'h0 : (cnt == 3'h5 ? cnt : cnt + 3'h1);
	assign o_osc_ok = (cnt == 3'h5);
endmodule
`default_nettype wire

/* File: sim/pmcc_chk.sv */
// Purpose: port checks for power mode control
// Assumes: WAKE_CYCLES of 4 in sim
// Notes: bound to the top module
`include "pmcc_map.vh"
`timescale 1ns/1ps
`default_nettype none
module pmcc_chk #(parameter NPERIPH = 8) (
	input wire i_core_clk, input wire i_nrst, input wire i_idle_req, input wire i_pd_req,
	input wire i_periph_irq, input wire [1:0] i_div_ratio, input wire i_remap_ram,
	input wire [NPERIPH-1:0] i_periph_off, input wire o_cpu_run, input wire o_core_clk_en,
	input wire o_periph_clk_en, input wire o_osc_on, input wire o_pll_keep,
	input wire o_pin_hold, input wire o_remap_ram, input wire [NPERIPH-1:0] o_periph_clk_on,
	input wire [1:0] o_mode);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	// power-down followed by its wake state
	sequence s_pd; o_mode == `ST_PD ##1 o_mode == `ST_WAKE; endsequence
	property p_idle; o_mode == `ST_RUN && i_idle_req && !i_pd_req |=> o_mode == `ST_IDLE
		&& !o_cpu_run && !o_core_clk_en && o_pll_keep; endproperty
	property p_irq; o_mode == `ST_IDLE && i_periph_irq |-> ##[1:3] o_mode == `ST_RUN; endproperty
	property p_pd; o_mode == `ST_RUN && i_pd_req |=> o_mode == `ST_PD && !o_osc_on && !o_pll_keep
		&& o_pin_hold; endproperty
	property p_pdq; o_mode == `ST_PD |-> !o_periph_clk_en && !o_cpu_run && o_pin_hold; endproperty
	property p_wake; s_pd |-> (o_mode == `ST_WAKE && !o_cpu_run && o_pin_hold) [*4]; endproperty
	// ratio held steady, so a quarter period is never cut short
	property p_div; o_periph_clk_en && i_div_ratio == `DIV_QUARTER
		&& $past(i_div_ratio, 4) == `DIV_QUARTER |=> !o_periph_clk_en [*3]; endproperty
	property p_off; o_mode == `ST_RUN && $past(o_mode) == `ST_RUN
		|-> o_periph_clk_on == ~$past(i_periph_off); endproperty
	property p_map; o_remap_ram == $past(i_remap_ram); endproperty
	a_idle: assert property (p_idle) else $error("idle entry wrong");
	a_irq: assert property (p_irq) else $error("idle not left");
	a_pd: assert property (p_pd) else $error("power-down entry wrong");
	a_pdq: assert property (p_pdq) else $error("power-down not quiet");
	a_wake: assert property (p_wake) else $error("wake too short");
	a_div: assert property (p_div) else $error("quarter period wrong");
	a_off: assert property (p_off) else $error("gating wrong");
	a_map: assert property (p_map) else $error("remap wrong");
endmodule
bind power_mode_clock_control pmcc_chk #(.NPERIPH(NPERIPH)) chk_u (.i_core_clk(i_core_clk),
	.i_nrst(i_nrst), .i_idle_req(i_idle_req), .i_pd_req(i_pd_req), .i_periph_irq(i_periph_irq),
	.i_div_ratio(i_div_ratio), .i_remap_ram(i_remap_ram), .i_periph_off(i_periph_off),
	.o_cpu_run(o_cpu_run), .o_core_clk_en(o_core_clk_en), .o_periph_clk_en(o_periph_clk_en),
	.o_osc_on(o_osc_on), .o_pll_keep(o_pll_keep), .o_pin_hold(o_pin_hold),
	.o_remap_ram(o_remap_ram), .o_periph_clk_on(o_periph_clk_on), .o_mode(o_mode));
`default_nettype wire

/* File: sim/tb_top.sv */
// Purpose: directed bench for power mode control
// Assumes: WAKE_CYCLES of 4
// Notes: inputs move on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	reg c = 0, r = 0, idl = 0, pd = 0, rm = 0, irq = 0;
	reg [1:0] dv = 2'h1;
	reg [7:0] off = 8'h00;
	reg [8:0] we = 9'h000, pin = 9'h000, edg = 9'h000, clr = 9'h000;
	wire run, cke, pen, oon, ok, pll, hld, rmo;
	wire [7:0] pon;
	wire [3:0] xi;
	wire [1:0] md;
	integer err_total = 0, compares = 0, n, k;
	initial forever #25 c = ~c;
	power_mode_clock_control #(.WAKE_CYCLES(4)) dut_u (.i_core_clk(c), .i_nrst(r),
		.i_idle_req(idl), .i_pd_req(pd), .i_div_ratio(dv), .i_remap_ram(rm),
		.i_periph_off(off), .i_ext_edge(edg), .i_ext_en(9'h1ff), .i_ext_wake_en(we),
		.i_ext_clear(clr), .i_periph_irq(irq), .i_osc_ok(ok), .i_ext_pin(pin),
		.o_cpu_run(run), .o_core_clk_en(cke), .o_periph_clk_en(pen), .o_osc_on(oon),
		.o_pll_keep(pll), .o_pin_hold(hld), .o_remap_ram(rmo), .o_periph_clk_on(pon),
		.o_ext_irq(xi), .o_mode(md));
	osc_model osc_u (.i_core_clk(c), .i_osc_on(oon), .o_osc_ok(ok));
	task summarize;
		begin
			if (err_total == 0 && compares > 0) $display("*** PASS ***");
			else $display("*** FAIL ***");
			$finish;
		end
	endtask
	task ck(input string s, input [8:0] e, input [8:0] g);
		begin
			compares = compares + 1;
			if (e !== g) begin
				err_total = err_total + 1;
				$display("CHECK FAILED %s exp %h got %h", s, e, g);
			end
		end
	endtask
	task w(input integer m); repeat (m) @(negedge c); endtask
	// bounded wait for a mode, a hang ends the run
	task wm(input [1:0] m);
		begin
			k = 0;
			while (md !== m && k < 60) begin w(1); k = k + 1; end
			if (k == 60) begin err_total = err_total + 1; summarize; end
		end
	endtask
	// strobes in 16 cycles; 8 cycles first to let the new ratio load
	task cs(input [1:0] q);
		begin dv = q; w(8); n = 0; repeat (16) begin w(1); n = n + pen; end end
	endtask
	initial begin
		w(3);
		r = 1;
		w(1);
		ck("mode", 2'h0, md);
		ck("run", 9'h001, oon & pll & run & cke & !hld);
		cs(2'h1); ck("div4", 9'h004, n);
		cs(2'h2); ck("div2", 9'h008, n);
		cs(2'h0); ck("div1", 9'h010, n);
		off = 8'h5a; rm = 1; w(2);
		ck("pon", 9'h0a5, pon);
		ck("remap", 9'h001, rmo);
		pin = 9'h104; w(6); ck("irq", 9'h005, xi);
		pin = 9'h000; w(6); ck("irq", 9'h000, xi);
		// edge pin: a short pulse is latched until software clears it
		edg = 9'h001; pin = 9'h001; w(2); pin = 9'h000; w(6);
		ck("edge", 9'h001, xi);
		clr = 9'h001; w(1); clr = 9'h000; w(4);
		ck("clear", 9'h000, xi);
		idl = 1; w(1); idl = 0; pd = 1; w(1); pd = 0;
		ck("idle", 9'h001, md);
		ck("cpu", 9'h001, !run & !cke & pll & oon);
		n = 0; repeat (16) begin w(1); n = n + pen; end
		ck("idiv", 9'h010, n);
		irq = 1; wm(2'h0); irq = 0;
		ck("resume", 9'h001, run);
		pd = 1; w(1); pd = 0; w(1);
		ck("pd", 9'h002, md);
		ck("pdout", 9'h001, !oon & !pll & hld);
		pin = 9'h100; w(8); ck("pd", 9'h002, md);
		we = 9'h100; wm(2'h3); n = 0;
		while (md === 2'h3 && n < 60) begin w(1); n = n + 1; end
		ck("wait", 9'h001, n >= 4 && n < 60);
		ck("back", 9'h001, run & !hld & oon);
		summarize;
	end
endmodule
`default_nettype wire
